/* sac_ctrl.sv */
// control of the 10-bit successive-approximation converter
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - channel select routes exactly one input to sample-and-hold
// - positive reference: pin, supply, or fixed 1.024/2.048/4.096V
// - one bit picks negative reference pin or ground
// - conversion clock: system clock over 2*(n+1), or rc oscillator
// - a full conversion takes 11.5 bit periods
// - control logic steps on the selected conversion clock
// - done flag set on every completion, held until software clears
// - runs in sleep only with rc oscillator selected
// - enabled completion in sleep wakes the device
// - on wake, vector if peripheral and global enables set, else continue inline
// - format bit: 0 left justified, 1 right justified
// - software writes stored right justified, read back shifted
// - converter enabled only while module-on bit is 1
// - start by go bit, external trigger, or continuous retrigger
// - on completion copy old result to previous if selected
// - completion clears go unless continuous, sets flags, accumulates
// - error and threshold flag after every or every second sample
// - setpoint error on same cadence decides threshold compare
// - math runs after conversion completes; handlers check threshold flag
// - go cleared early stores partial result, fills with last bit
// - rc start waits one instruction; in sleep powers down if irq disabled
// - rising edge of selected trigger sets go; code zero disables
// - trigger in sleep without rc is held until sleep ends
module sac_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // configuration and software strobes
  input wire sac_pkg::sac_cfg_t cfg,
  input wire sac_pkg::sac_irq_en_t irq_en,
  input wire logic go_set,
  input wire logic go_clear,
  input wire logic done_flag_clear,
  input wire logic math_flag_clear,
  input wire logic thresh_flag_clear,
  input wire logic [1:0] result_wr_be,
  input wire logic [15:0] result_wr_data,
  // computation settings
  input wire logic [9:0] setpoint,
  input wire logic [15:0] upper_threshold,
  input wire logic [15:0] lower_threshold,
  // system
  input wire logic sleep_mode,
  input wire logic insn_pulse,
  input wire logic [31:0] trigger_sources,
  input wire logic rc_osc,
  // analog side
  input wire logic comp_in,
  output logic [5:0] channel_route,
  output logic [2:0] pos_ref_route,
  output logic neg_ref_route,
  output logic sample_enable,
  output logic [9:0] sar_trial,
  output logic converter_powered,
  // status
  output logic go_bit,
  output logic conversion_done_flag,
  output logic math_done_flag,
  output logic threshold_flag,
  output logic [15:0] result_pair,
  output logic [15:0] previous_result_reg,
  output logic [15:0] accumulator_reg,
  output logic [15:0] error_value_reg,
  output logic [15:0] setpoint_error_value,
  output logic wake_req,
  output logic isr_vector
);
  import sac_pkg::*;

  sac_state_t state_q;
  logic half_tick;
  logic rc_sel;
  logic run_ok;
  logic step;
  logic [4:0] half_q;
  logic [3:0] bit_q;
  logic bits_done_q;
  logic last_bit_q;
  logic [9:0] sar_q;
  logic [9:0] final_q;
  logic [9:0] prev_sample_q;
  logic pair_q;
  logic [15:0] res_q;
  logic go_q;
  logic pend_q;
  logic pd_q;
  logic trig_prev_q;
  logic trig_sel;
  logic trig_edge;
  logic trig_go;
  logic [15:0] stpe_d;
  logic [15:0] err_d;

  // fill the bits not yet converted with the last converted bit
  function automatic logic [9:0] sac_fill(input logic [9:0] v, input logic [3:0] idx,
                                          input logic b, input logic done);
    logic [9:0] r;
    r = v;
    for (int i = 0; i < SAC_RES_W; i++)
      if (!done && i <= int'(idx))
        r[i] = b;
    return r;
  endfunction : sac_fill

  // ==================================================================
  // conversion clock
  assign rc_sel = cfg.conv_clock_source_bit == SAC_CLK_RC;

  sac_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .rc_sel(rc_sel),
    .div_n(cfg.clock_divider_field),
    .rc_osc(rc_osc),
    .half_tick(half_tick)
  );

  // progress only with module on, and in sleep only on the rc oscillator
  assign run_ok = cfg.module_on_bit && (!sleep_mode || rc_sel);
  assign step = half_tick && run_ok;

  // ==================================================================
  // auto trigger edge detect
  assign trig_sel = trigger_sources[cfg.auto_trigger_select];
  assign trig_edge = trig_sel && !trig_prev_q && cfg.auto_trigger_select != SAC_TRIG_OFF;
  assign trig_go = trig_edge && !(sleep_mode && !rc_sel);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      trig_prev_q <= 1'b0;
    else
      trig_prev_q <= trig_sel;
  end

  // trigger held while asleep on the divided clock
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !cfg.module_on_bit)
      pend_q <= 1'b0;
    else if (trig_edge && sleep_mode && !rc_sel)
      pend_q <= 1'b1;
    else if (!sleep_mode)
      pend_q <= 1'b0;
  end

  // go bit: any set beats a clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !cfg.module_on_bit)
      go_q <= 1'b0;
    else if (go_set || trig_go || (pend_q && !sleep_mode))
      go_q <= 1'b1;
    else if (go_clear)
      go_q <= 1'b0;
    else if (state_q == SAC_STORE && !cfg.continuous_mode_bit)
      go_q <= 1'b0;
  end

  // ==================================================================
  // conversion sequencer
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      state_q <= SAC_IDLE;
    else if (!cfg.module_on_bit)
      state_q <= SAC_IDLE;
    else
    begin
      case (state_q)
        SAC_IDLE:
          if (go_q && run_ok && !pd_q)
            state_q <= rc_sel ? SAC_WAIT_INSN : SAC_CONVERT;
        SAC_WAIT_INSN:
          if (insn_pulse)
            state_q <= SAC_CONVERT;
        SAC_CONVERT:
          if (!go_q)
            state_q <= SAC_STORE;
          else if (step && half_q == SAC_HALF_TOTAL - 5'h01)
            state_q <= SAC_STORE;
        SAC_STORE:
          state_q <= SAC_MATH;
        SAC_MATH:
          state_q <= SAC_IDLE;
        default:
          state_q <= SAC_IDLE;
      endcase
    end
  end

  // half period counter and successive approximation
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || state_q != SAC_CONVERT)
    begin
      half_q <= 5'h00;
      bit_q <= SAC_MSB_IDX;
      bits_done_q <= 1'b0;
      last_bit_q <= 1'b0;
      sar_q <= SAC_SAR_START;
    end
    else if (step)
    begin
      half_q <= half_q + 5'h01;
      if (half_q >= SAC_FIRST_RES && half_q[0] && !bits_done_q)
      begin
        sar_q[bit_q] <= comp_in;
        last_bit_q <= comp_in;
        if (bit_q == 4'h0)
          bits_done_q <= 1'b1;
        else
        begin
          sar_q[bit_q - 4'h1] <= 1'b1;
          bit_q <= bit_q - 4'h1;
        end
      end
    end
  end

  // ==================================================================
  // result, previous result and accumulator
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      final_q <= 10'h000;
    else if (state_q == SAC_CONVERT)
      final_q <= sac_fill(sar_q, bit_q, last_bit_q, bits_done_q);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      res_q <= 16'h0000;
      previous_result_reg <= 16'h0000;
      accumulator_reg <= 16'h0000;
    end
    else if (state_q == SAC_STORE)
    begin
      if (cfg.previous_source_select)
        previous_result_reg <= res_q;
      res_q <= {6'h00, final_q};
      accumulator_reg <= accumulator_reg + {6'h00, final_q};
    end
    else
    begin
      if (result_wr_be[0])
        res_q[7:0] <= result_wr_data[7:0];
      if (result_wr_be[1])
        res_q[15:8] <= result_wr_data[15:8];
    end
  end

  // justified view of the stored value
  assign result_pair = (cfg.result_format_bit == SAC_FMT_LEFT) ?
                       (res_q << SAC_LJ_SHIFT) : res_q;

  // ==================================================================
  // post-conversion math, one cycle after the result lands
  assign stpe_d = {6'h00, final_q} - {6'h00, setpoint};
  assign err_d = cfg.double_sample_enable ? ({6'h00, final_q} - {6'h00, prev_sample_q}) : stpe_d;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pair_q <= 1'b0;
      prev_sample_q <= 10'h000;
      error_value_reg <= 16'h0000;
      setpoint_error_value <= 16'h0000;
    end
    else if (state_q == SAC_MATH)
    begin
      pair_q <= cfg.double_sample_enable ? !pair_q : 1'b0;
      prev_sample_q <= final_q;
      if (!cfg.double_sample_enable || pair_q)
      begin
        error_value_reg <= err_d;
        setpoint_error_value <= stpe_d;
      end
    end
  end

  // ==================================================================
  // flags: hardware set wins over software clear
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      conversion_done_flag <= 1'b0;
      math_done_flag <= 1'b0;
      threshold_flag <= 1'b0;
    end
    else
    begin
      if (state_q == SAC_STORE)
        conversion_done_flag <= 1'b1;
      else if (done_flag_clear)
        conversion_done_flag <= 1'b0;
      if (state_q == SAC_STORE)
        math_done_flag <= 1'b1;
      else if (math_flag_clear)
        math_done_flag <= 1'b0;
      // sign of setpoint error picks which bound is compared
      if (state_q == SAC_MATH && (!cfg.double_sample_enable || pair_q) &&
          (stpe_d[15] ? ($signed(err_d) < $signed(lower_threshold))
                      : ($signed(err_d) > $signed(upper_threshold))))
        threshold_flag <= 1'b1;
      else if (thresh_flag_clear)
        threshold_flag <= 1'b0;
    end
  end

  // power down after a sleep conversion with the interrupt disabled
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !cfg.module_on_bit || !sleep_mode)
      pd_q <= 1'b0;
    else if (state_q == SAC_STORE && rc_sel && !irq_en.conversion_irq_enable)
      pd_q <= 1'b1;
  end

  // wake and vector requests toward the core
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      wake_req <= 1'b0;
      isr_vector <= 1'b0;
    end
    else
    begin
      wake_req <= sleep_mode && conversion_done_flag && irq_en.conversion_irq_enable;
      isr_vector <= conversion_done_flag && irq_en.conversion_irq_enable &&
                    irq_en.peripheral_irq_enable && irq_en.global_irq_enable;
    end
  end

  // ==================================================================
  // analog side routing
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      channel_route <= 6'h00;
      pos_ref_route <= SAC_PREF_PIN;
      neg_ref_route <= 1'b0;
      sample_enable <= 1'b0;
      sar_trial <= 10'h000;
      converter_powered <= 1'b0;
    end
    else
    begin
      channel_route <= cfg.channel_select_reg;
      pos_ref_route <= cfg.positive_ref_select;
      neg_ref_route <= cfg.negative_ref_select;
      sample_enable <= cfg.module_on_bit && state_q != SAC_CONVERT;
      sar_trial <= sar_q;
      converter_powered <= cfg.module_on_bit && !pd_q;
    end
  end

  assign go_bit = go_q;

  // ==================================================================
  // checks
  property p_conv_len;
    @(posedge ref_clk) disable iff (!rst_b)
    (state_q == SAC_CONVERT && go_q && step && half_q == SAC_HALF_TOTAL - 5'h01
     && cfg.module_on_bit) |=> state_q == SAC_STORE;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion did not end after 23 half periods");

  property p_done_flag;
    @(posedge ref_clk) disable iff (!rst_b)
    state_q == SAC_STORE |=> conversion_done_flag && math_done_flag;
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("completion did not raise flags");

  property p_go_clear;
    @(posedge ref_clk) disable iff (!rst_b)
    (state_q == SAC_STORE && !cfg.continuous_mode_bit && !go_set && !trig_go && !pend_q)
    |=> !go_q;
  endproperty
  a_go_clear: assert property (p_go_clear)
    else $error("go not cleared on completion");

  property p_prev_copy;
    @(posedge ref_clk) disable iff (!rst_b)
    (state_q == SAC_STORE && cfg.previous_source_select)
    |=> previous_result_reg == $past(res_q) && res_q == {6'h00, $past(final_q)};
  endproperty
  a_prev_copy: assert property (p_prev_copy)
    else $error("previous result not copied");

  property p_off_idle;
    @(posedge ref_clk) disable iff (!rst_b)
    !cfg.module_on_bit |=> state_q == SAC_IDLE && !go_q;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("converter active while off");

  property p_sleep_hold;
    @(posedge ref_clk) disable iff (!rst_b)
    (sleep_mode && !rc_sel && state_q == SAC_CONVERT && go_q) |=> $stable(half_q);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("conversion advanced in sleep without rc clock");

  property p_trig_go;
    @(posedge ref_clk) disable iff (!rst_b)
    (trig_edge && !sleep_mode && cfg.module_on_bit) |=> go_q;
  endproperty
  a_trig_go: assert property (p_trig_go)
    else $error("trigger edge did not set go");

  property p_trig_pend;
    @(posedge ref_clk) disable iff (!rst_b)
    (trig_edge && sleep_mode && !rc_sel && cfg.module_on_bit) |=> pend_q && !$rose(go_q);
  endproperty
  a_trig_pend: assert property (p_trig_pend)
    else $error("sleep trigger not held");

  property p_math_after;
    @(posedge ref_clk) disable iff (!rst_b)
    $changed(error_value_reg) |-> $past(state_q) == SAC_MATH;
  endproperty
  a_math_after: assert property (p_math_after)
    else $error("math updated outside math step");

  property p_rc_wait;
    @(posedge ref_clk) disable iff (!rst_b)
    (state_q == SAC_IDLE && rc_sel && go_q && run_ok && !pd_q && cfg.module_on_bit)
    |=> state_q == SAC_WAIT_INSN;
  endproperty
  a_rc_wait: assert property (p_rc_wait)
    else $error("rc start skipped instruction wait");

  c_full: cover property (@(posedge ref_clk) disable iff (!rst_b)
    state_q == SAC_CONVERT && bits_done_q ##1 state_q == SAC_STORE);
  c_abort: cover property (@(posedge ref_clk) disable iff (!rst_b)
    state_q == SAC_CONVERT && !go_q && !bits_done_q);
  c_thresh: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(threshold_flag));

endmodule : sac_ctrl
`default_nettype wire

/* sac_pkg.sv */
// package for the successive-approximation converter control block
package sac_pkg;

  // ==================================================================
  // widths and conversion timing
  localparam int SAC_RES_W = 10;                 // result bits
  localparam logic [4:0] SAC_HALF_TOTAL = 5'h17; // 11.5 bit periods in half periods
  localparam logic [4:0] SAC_FIRST_RES = 5'h03;  // half period of first bit decision
  localparam logic [3:0] SAC_MSB_IDX = 4'h9;     // first bit decided
  localparam logic [9:0] SAC_SAR_START = 10'h200; // trial word before the first decision
  localparam int SAC_LJ_SHIFT = 6;               // left-justify shift

  // ==================================================================
  // field codes
  localparam logic [4:0] SAC_TRIG_OFF = 5'h00;   // auto trigger disabled
  localparam logic SAC_FMT_LEFT = 1'b0;          // result format left justified
  localparam logic SAC_CLK_RC = 1'b1;            // conversion clock from rc oscillator
  localparam logic [2:0] SAC_PREF_PIN = 3'h0;    // positive ref: reference pin
  localparam logic [2:0] SAC_PREF_SUPPLY = 3'h1; // positive ref: supply
  localparam logic [2:0] SAC_PREF_F1 = 3'h2;     // fixed ref 1.024V
  localparam logic [2:0] SAC_PREF_F2 = 3'h3;     // fixed ref 2.048V
  localparam logic [2:0] SAC_PREF_F4 = 3'h4;     // fixed ref 4.096V
  localparam logic SAC_NREF_PIN = 1'b1;          // negative ref: pin, else ground

  // ==================================================================
  // configuration as software holds it
  typedef struct packed {
    logic module_on_bit;
    logic conv_clock_source_bit;
    logic [5:0] clock_divider_field;
    logic [5:0] channel_select_reg;
    logic [2:0] positive_ref_select;
    logic negative_ref_select;
    logic result_format_bit;
    logic previous_source_select;
    logic continuous_mode_bit;
    logic double_sample_enable;
    logic [4:0] auto_trigger_select;
  } sac_cfg_t;

  // interrupt enables
  typedef struct packed {
    logic conversion_irq_enable;
    logic peripheral_irq_enable;
    logic global_irq_enable;
  } sac_irq_en_t;

  // conversion sequencer states
  typedef enum logic [2:0] {
    SAC_IDLE,
    SAC_WAIT_INSN,
    SAC_CONVERT,
    SAC_STORE,
    SAC_MATH
  } sac_state_t;

endpackage : sac_pkg

/* sac_tick_gen.sv */
// half bit-period tick generator: system clock divider or synchronised rc oscillator
`timescale 1ns/100ps
`default_nettype none
module sac_tick_gen (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // selection
  input wire logic rc_sel,
  input wire logic [5:0] div_n,
  // rc oscillator pin
  input wire logic rc_osc,
  // tick out
  output logic half_tick
);
  import sac_pkg::*;

  logic [5:0] cnt_q;
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic rc_edge;

  // ==================================================================
  // rc oscillator synchroniser, edges mark half periods
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= rc_osc;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign rc_edge = sync2_q ^ prev_q;

  // divider: half period is n+1 cycles, full period 2*(n+1)
  // a count left above a lowered n restarts at once instead of wrapping past 63
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      cnt_q <= 6'h00;
    else if (rc_sel || cnt_q >= div_n)
      cnt_q <= 6'h00;
    else
      cnt_q <= cnt_q + 6'h01;
  end

  // source select
  assign half_tick = rc_sel ? rc_edge : (cnt_q == div_n);

  // ==================================================================
  // checks
  property p_div_period;
    @(posedge ref_clk) disable iff (!rst_b)
    (!rc_sel && half_tick && $stable(div_n)) |=> !half_tick || div_n == 6'h00;
  endproperty
  a_div_period: assert property (p_div_period)
    else $error("divided tick came too early");

endmodule : sac_tick_gen
`default_nettype wire

/* sac_analog_model.sv */
// comparator array model that answers the trial word of the sequencer
`timescale 1ns/100ps
`default_nettype none
module sac_analog_model (
  // analog side of the sequencer
  input wire logic [5:0] channel_route,
  input wire logic [9:0] sar_trial,
  // analog level of the routed input
  input wire logic [9:0] level,
  // comparator result
  output logic comp_in
);
  // ==================================================================
  // comparison
  // one when the input sits at or above the trial level; the level is
  // held still by the bench for the whole conversion, as after settling;
  // the routed pin is taken as an input already set to analog
  assign comp_in = (level >= sar_trial);
endmodule : sac_analog_model
`default_nettype wire

/* tb_sac_ctrl.sv */
// self-checking testbench of the converter control block
`timescale 1ns/100ps
`default_nettype none
module tb_sac_ctrl;
  import sac_pkg::*;
  // ==================================================================
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic rc_osc = 1'b0;
  logic insn_pulse = 1'b0;
  sac_cfg_t cfg = '0;
  sac_irq_en_t irq_en = '0;
  logic go_set = 1'b0;
  logic go_clr = 1'b0;
  logic done_clr = 1'b0;
  logic math_clr = 1'b0;
  logic thr_clr = 1'b0;
  logic sleep_mode = 1'b0;
  logic [1:0] wr_be = 2'h0;
  logic [15:0] wr_data = 16'h0000;
  logic [9:0] setpoint = 10'h000;
  logic [15:0] upper = 16'h0000;
  logic [15:0] lower = 16'h0000;
  logic [31:0] trig = 32'h00000000;
  logic [9:0] level = 10'h000;
  logic [9:0] v1 = 10'h000;
  logic comp_in, neg_ref, sample_en, powered, go_bit, done_flag, math_flag, thr_flag, wake, isr;
  logic [5:0] chan;
  logic [2:0] pref;
  logic [9:0] trial;
  logic [15:0] result, prev, acc, err, spe;
  logic [31:0] exp_q[$];
  logic [31:0] note;
  logic done_d = 1'b0;
  logic [15:0] acc_exp = 16'h0000;
  logic [15:0] spe_e = 16'h0000;
  logic [15:0] err_e = 16'h0000;
  logic thr_e = 1'b0;
  logic pair_e = 1'b0;
  logic [9:0] last_v = 10'h000;
  int fails = 0;
  int samples_checked = 0;
  int seed = 46858;

  // clocks: system clock, free-running rc oscillator, instruction pulses
  always #5 ref_clk = ~ref_clk;
  always #37 rc_osc = ~rc_osc;
  always @(posedge ref_clk) insn_pulse <= ~insn_pulse;

  // ==================================================================
  // design and analog partner
  sac_ctrl i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .cfg(cfg), .irq_en(irq_en),
    .go_set(go_set), .go_clear(go_clr), .done_flag_clear(done_clr), .math_flag_clear(math_clr),
    .thresh_flag_clear(thr_clr), .result_wr_be(wr_be), .result_wr_data(wr_data),
    .setpoint(setpoint), .upper_threshold(upper), .lower_threshold(lower),
    .sleep_mode(sleep_mode), .insn_pulse(insn_pulse), .trigger_sources(trig), .rc_osc(rc_osc),
    .comp_in(comp_in), .channel_route(chan), .pos_ref_route(pref), .neg_ref_route(neg_ref),
    .sample_enable(sample_en), .sar_trial(trial), .converter_powered(powered), .go_bit(go_bit),
    .conversion_done_flag(done_flag), .math_done_flag(math_flag), .threshold_flag(thr_flag),
    .result_pair(result), .previous_result_reg(prev), .accumulator_reg(acc),
    .error_value_reg(err), .setpoint_error_value(spe), .wake_req(wake), .isr_vector(isr));
  sac_analog_model i_ana (.channel_route(chan), .sar_trial(trial), .level(level),
    .comp_in(comp_in));

  // ==================================================================
  // comparison and verdict
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // one conversion: note the expectation, start it, wait bounded, check math
  task automatic convert(input logic [9:0] v, input int k, input int lo, input int hi,
    input logic keep, input int ab = -1);
    int cyc;
    cyc = 0;
    level <= v;
    acc_exp = acc_exp + {6'h00, v};
    exp_q.push_back({acc_exp, cfg.result_format_bit ? {6'h00, v} : {v, 6'h00}});
    if (k == 0)
      go_set <= 1'b1;
    else
      trig[k] <= 1'b1;
    @(posedge ref_clk);
    go_set <= 1'b0;
    while (done_flag !== 1'b1 && cyc < hi)
    begin
      go_clr <= (cyc == ab);
      @(posedge ref_clk);
      cyc++;
    end
    go_clr <= 1'b0;
    if (done_flag !== 1'b1)
    begin
      fails++;
      conclude();
    end
    check("time", 16'(cyc >= lo), 16'h0001);
    check("go", go_bit, 16'(cfg.continuous_mode_bit));
    trig <= 32'h00000000;
    repeat (3) @(posedge ref_clk);
    // math only on every conversion, or every second one in double-sample mode
    thr_e = 1'b0;
    if (!cfg.double_sample_enable || pair_e)
    begin
      spe_e = {6'h00, v} - {6'h00, setpoint};
      err_e = cfg.double_sample_enable ? {6'h00, v} - {6'h00, last_v} : spe_e;
      thr_e = ($signed(spe_e) < 0) ? ($signed(err_e) < $signed(lower))
        : ($signed(err_e) > $signed(upper));
    end
    pair_e = cfg.double_sample_enable && !pair_e;
    last_v = v;
    check("spe", spe, spe_e);
    check("err", err, err_e);
    check("thr", thr_flag, 16'(thr_e));
    check("math", math_flag, 16'h0001);
    if (!keep)
    begin
      done_clr <= 1'b1;
      math_clr <= 1'b1;
      thr_clr <= 1'b1;
      @(posedge ref_clk);
      done_clr <= 1'b0;
      math_clr <= 1'b0;
      thr_clr <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check("clear", done_flag, 16'h0000);
    end
  endtask : convert

  // result watcher: oldest note against each completed conversion
  always @(posedge ref_clk)
  begin
    done_d <= done_flag;
    if (done_flag === 1'b1 && done_d === 1'b0)
    begin
      note = exp_q.pop_front();
      check("result", result, note[15:0]);
      check("acc", acc, note[31:16]);
    end
  end

  // ==================================================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    check("reset go", go_bit, 16'h0000);
    check("reset result", result, 16'h0000);
    for (int i = 0; i < 10; i++)
    begin
      cfg.positive_ref_select <= 3'(i % 5);
      cfg.negative_ref_select <= 1'(i / 5);
      cfg.channel_select_reg <= 6'($random(seed));
      repeat (3) @(posedge ref_clk);
      check("pref", pref, 16'(i % 5));
      check("nref", neg_ref, 16'(i / 5));
      check("chan", chan, {10'h000, cfg.channel_select_reg});
    end
    $display("test routing done");
    go_set <= 1'b1;
    @(posedge ref_clk);
    go_set <= 1'b0;
    cfg.module_on_bit <= 1'b1;
    trig <= 32'h00000001;
    repeat (3) @(posedge ref_clk);
    check("go off", go_bit, 16'h0000);
    check("power", powered, 16'h0001);
    check("sample", sample_en, 16'h0001);
    trig <= 32'h00000000;
    setpoint <= 10'($random(seed));
    upper <= 16'($random(seed));
    lower <= 16'($random(seed));
    $display("test refusal done");
    for (int k = 0; k < 32; k++)
    begin
      cfg.clock_divider_field <= 6'(k % 4);
      cfg.result_format_bit <= 1'($random(seed));
      cfg.auto_trigger_select <= 5'(k);
      @(posedge ref_clk);
      convert(10'($random(seed)), k, 23 * (k % 4 + 1), 23 * (k % 4 + 1) + 8, 1'b0);
    end
    convert(10'h3ff, 0, 0, 56, 1'b0, 50);
    $display("test starts done");
    cfg.result_format_bit <= 1'b1;
    cfg.previous_source_select <= 1'b1;
    cfg.clock_divider_field <= 6'h00;
    cfg.auto_trigger_select <= 5'h00;
    v1 <= 10'($random(seed));
    @(posedge ref_clk);
    convert(v1, 0, 23, 31, 1'b0);
    convert(10'($random(seed)), 0, 23, 31, 1'b0);
    check("prev", prev, {6'h00, v1});
    $display("test previous done");
    wr_be <= 2'h3;
    level <= 10'h000;
    @(posedge ref_clk);
    wr_be <= 2'h1;
    wr_data <= 16'h00ff;
    cfg.result_format_bit <= 1'b0;
    @(posedge ref_clk);
    wr_be <= 2'h0;
    repeat (2) @(posedge ref_clk);
    check("wr left", result, 16'h3fc0);
    cfg.result_format_bit <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("wr right", result, 16'h00ff);
    $display("test write done");
    cfg.continuous_mode_bit <= 1'b1;
    v1 <= 10'($random(seed));
    @(posedge ref_clk);
    convert(v1, 0, 23, 31, 1'b0);
    cfg.continuous_mode_bit <= 1'b0;
    convert(v1, 0, 0, 31, 1'b0);
    cfg.double_sample_enable <= 1'b1;
    @(posedge ref_clk);
    convert(10'($random(seed)), 0, 23, 31, 1'b0);
    convert(10'($random(seed)), 0, 23, 31, 1'b0);
    $display("test modes done");
    cfg.conv_clock_source_bit <= 1'b1;
    irq_en <= 3'b110;
    sleep_mode <= 1'b1;
    @(posedge ref_clk);
    convert(10'($random(seed)), 0, 0, 800, 1'b1);
    repeat (2) @(posedge ref_clk);
    check("wake", wake, 16'h0001);
    check("inline", isr, 16'h0000);
    irq_en.global_irq_enable <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("vector", isr, 16'h0001);
    sleep_mode <= 1'b0;
    check("notes left", 16'(exp_q.size()), 16'h0000);
    $display("test sleep done");
    conclude();
  end
endmodule : tb_sac_ctrl
`default_nettype wire
